// file: verilog/nvc_controller.sv
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module nvc_controller
    import nvc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    nvc_link_if.ctrl link
);
    // ==============================================================
    // State
    nvc_state_t state; // Sequencer
    logic aw_held; // Address taken, awaiting data
    logic w_held; // Data taken, awaiting address
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb; // Byte lanes taken with the data
    logic [15:0] wdata; // Bytes for the next write
    logic last_ack; // Answer of last transfer
    logic [15:0] last_rdata;
    logic do_write; // Both halves present

    // ==============================================================
    // Write channels, either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == CSR_CMD || aw_addr == CSR_WDATA) ? RESP_OKAY
                : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Write data register, low two lanes only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata <= 16'h0000;
        end else if (do_write && aw_addr == CSR_WDATA) begin
            if (w_strb[0]) begin
                wdata[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                wdata[15:8] <= w_data[15:8];
            end
        end
    end

    // ==============================================================
    // Transfer sequencer; a command while busy is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= NVC_IDLE;
            link.req <= 1'b0;
            link.dev_sel <= 7'h00;
            link.rd <= 1'b0;
            link.wide <= 1'b0;
            link.ptr <= 8'h00;
            link.wdata <= 16'h0000;
            last_ack <= 1'b0;
            last_rdata <= 16'h0000;
        end else begin
            case (state)
                NVC_IDLE: begin
                    if (do_write && aw_addr == CSR_CMD) begin
                        state <= NVC_WAIT;
                        link.req <= 1'b1;
                        link.ptr <= w_data[7:0];
                        link.dev_sel <= w_data[CMD_DEV_LSB +: 7];
                        link.rd <= w_data[CMD_READ_BIT];
                        link.wide <= w_data[CMD_WIDE_BIT];
                        link.wdata <= wdata;
                    end
                end
                NVC_WAIT: begin
                    // Refusal during a save shows as a clear ack
                    if (link.done) begin
                        state <= NVC_IDLE;
                        link.req <= 1'b0;
                        last_ack <= link.ack;
                        if (link.ack && link.rd) begin
                            last_rdata <= link.rdata;
                        end
                    end
                end
                default: begin
                    state <= NVC_IDLE;
                    link.req <= 1'b0;
                end
            endcase
        end
    end

    // ==============================================================
    // Read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                CSR_WDATA: s_axi_rdata <= {16'h0000, wdata};
                CSR_STATUS: s_axi_rdata <= {30'h0000_0000, last_ack, state == NVC_WAIT};
                CSR_RDATA: s_axi_rdata <= {16'h0000, last_rdata};
                CSR_CMD: s_axi_rdata <= {14'h0000, link.wide, link.rd, 1'b0,
                    link.dev_sel, link.ptr};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// file: verilog/nvc_pkg.sv
package nvc_pkg;
    // ==============================================================
    // Device register pointers
    localparam logic [7:0] REG_DIVIDER = 8'h02;
    localparam logic [7:0] REG_TRIM_HI = 8'h08;
    localparam logic [7:0] REG_TRIM_LO = 8'h09;
    localparam logic [7:0] REG_BUS_ADDR = 8'h0D;
    localparam logic [7:0] REG_OFFSET = 8'h0E;
    localparam logic [7:0] REG_RANGE = 8'h37;
    localparam logic [7:0] REG_COMMIT = 8'h3F;
    // ==============================================================
    // Field positions
    localparam int DITHER_BIT = 4;
    localparam int DEFER_BIT = 3;
    localparam int TRIM_SHIFT = 6;
    localparam int OFFSET_W = 5;
    localparam logic [3:0] EXP_MAX = 4'h8;
    // ==============================================================
    // Factory defaults
    localparam logic [7:0] DIVIDER_RST = 8'hE0;
    localparam logic [15:0] TRIM_RST = 16'h7D00;
    localparam logic [7:0] BUS_ADDR_RST = 8'hF0;
    localparam logic [4:0] FACTORY_OS_RST = 5'h12;
    // Upper four address bits, arbitrary value
    localparam logic [3:0] DEV_ID_HI = 4'hA;
    // ==============================================================
    // Frequency plan in kHz
    localparam logic [31:0] RANGE_BASE_KHZ = 32'h0001_6800;
    localparam logic [31:0] RANGE_STEP_KHZ = 32'h0000_1400;
    localparam logic [31:0] TRIM_STEP_KHZ = 32'h0000_000A;
    // ==============================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int NV_WRITE_US = 10000;
    localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
    // ==============================================================
    // Controller register map, AXI4-Lite byte addresses
    localparam logic [3:0] CSR_CMD = 4'h0;
    localparam logic [3:0] CSR_WDATA = 4'h4;
    localparam logic [3:0] CSR_STATUS = 4'h8;
    localparam logic [3:0] CSR_RDATA = 4'hC;
    localparam int CMD_DEV_LSB = 8;
    localparam int CMD_READ_BIT = 16;
    localparam int CMD_WIDE_BIT = 17;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ==============================================================
    // Controller sequencer
    typedef enum logic [0:0] {
        NVC_IDLE = 1'b0,
        NVC_WAIT = 1'b1
    } nvc_state_t;
endpackage

// file: verilog/nvc_link_if.sv
`timescale 1ns/1ps
// Transfer-level view of the 2-wire bus
interface nvc_link_if;
    logic req; // Transfer request, held until done
    logic [6:0] dev_sel; // Seven-bit slave address
    logic rd; // 1 read, 0 write
    logic wide; // Two data bytes
    logic [7:0] ptr; // Register pointer
    logic [15:0] wdata; // Write bytes, first in high half
    logic done; // One-cycle answer pulse
    logic ack; // Acknowledge with done
    logic [15:0] rdata; // Read bytes, first in high half
    modport ctrl (output req, dev_sel, rd, wide, ptr, wdata, input done, ack, rdata);
    modport dev (input req, dev_sel, rd, wide, ptr, wdata, output done, ack, rdata);
endinterface

// file: verilog/nvc_device.sv
`timescale 1ns/1ps
module nvc_device
    import nvc_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    nvc_link_if.dev link,
    output logic [3:0] divider_exponent,
    output logic dither_depth_select,
    output logic [4:0] offset_setting,
    output logic [9:0] trim_value,
    output logic [31:0] master_khz,
    output logic [31:0] output_khz,
    output logic nv_busy
);
    // ==============================================================
    // Working and stored copies
    // Working copies steer the oscillator; stored copies outlive reset
    logic [7:0] divider; // Working divider and dither
    logic [15:0] trim; // Working trim word
    logic [7:0] bus_addr; // Working bus address
    logic [4:0] offset; // Working offset
    // Stored copies start at factory contents and are never reset
    logic [7:0] nv_divider = DIVIDER_RST; // Stored copies
    logic [15:0] nv_trim = TRIM_RST;
    logic [7:0] nv_bus_addr = BUS_ADDR_RST;
    logic [4:0] nv_offset = FACTORY_OS_RST;
    // Save timing and transfer decode
    logic [31:0] nv_count; // Save cycle counter
    logic take; // New transfer taken
    logic hit; // Address match
    logic wr_ok; // Accepted write
    logic save_now; // Start of a save
    // Next values of the working registers
    logic [7:0] next_divider;
    logic [15:0] next_trim;
    logic [7:0] next_bus_addr;
    logic [4:0] next_offset;

    // Register read, used for both bytes of a wide read
    // A single read keeps its byte in the high half
    function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [7:0] dv,
        input logic [15:0] tr, input logic [7:0] ba, input logic [4:0] of);
        case (p)
            REG_DIVIDER: rd_byte = dv;
            REG_TRIM_HI: rd_byte = tr[15:8];
            REG_TRIM_LO: rd_byte = {tr[7:6], 6'h00};
            REG_BUS_ADDR: rd_byte = ba;
            REG_OFFSET: rd_byte = {3'b111, of};
            REG_RANGE: rd_byte = {3'b000, FACTORY_OS_RST};
            default: rd_byte = 8'h00;
        endcase
    endfunction

    // Registers whose change starts an automatic save
    function automatic logic is_setting_reg(input logic [7:0] p);
        case (p)
            REG_DIVIDER, REG_TRIM_HI, REG_TRIM_LO, REG_OFFSET: is_setting_reg = 1'b1;
            default: is_setting_reg = 1'b0;
        endcase
    endfunction

    // ==============================================================
    // Transfer decode
    // A held request is taken once; the answer pulse masks it
    assign take = link.req && !link.done;
    // Upper address bits fixed, low three from the bus-address register
    assign hit = link.dev_sel == {DEV_ID_HI, bus_addr[2:0]};
    // Writes are refused while a save runs or the address misses
    assign wr_ok = take && hit && !nv_busy && !link.rd;

    // New working values; a wide write walks to the next pointer only at the high trim byte
    always_comb begin
        next_divider = divider;
        next_trim = trim;
        next_bus_addr = bus_addr;
        next_offset = offset;
        if (wr_ok) begin
            // A wide write at the high trim byte fills both bytes
            case (link.ptr)
                REG_DIVIDER: next_divider = link.wdata[15:8];
                REG_TRIM_HI: begin
                    next_trim[15:8] = link.wdata[15:8];
                    if (link.wide) begin
                        next_trim[7:6] = link.wdata[7:6];
                    end
                end
                // Only the top two bits of the low trim byte exist
                REG_TRIM_LO: next_trim[7:6] = link.wdata[15:14];
                // Upper nibble always reads as one
                REG_BUS_ADDR: next_bus_addr = {4'hF, link.wdata[11:8]};
                REG_OFFSET: next_offset = link.wdata[12:8];
                // Range and commit pointers store nothing
                default: next_offset = offset;
            endcase
        end
    end

    // Save trigger: commit, bus-address write, or auto mode change
    // Range writes and unknown pointers never start a save
    always_comb begin
        save_now = 1'b0;
        if (wr_ok) begin
            if (link.ptr == REG_COMMIT) begin
                save_now = 1'b1;
            end else if (link.ptr == REG_BUS_ADDR) begin
                save_now = 1'b1;
            // Auto mode only; a set defer bit waits for the commit
            end else if (!bus_addr[DEFER_BIT] && is_setting_reg(link.ptr)) begin
                save_now = 1'b1;
            end
        end
    end

    // ==============================================================
    // Working registers reload from storage at reset
    // Reset stands in for a power cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider <= nv_divider;
            trim <= nv_trim;
            bus_addr <= nv_bus_addr;
            offset <= nv_offset;
        end else begin
            divider <= next_divider;
            trim <= next_trim;
            bus_addr <= next_bus_addr;
            offset <= next_offset;
        end
    end

    // Storage keeps its contents through reset, like a real array
    // A bus-address save stores that register alone, deferred settings stay unsaved
    always_ff @(posedge aclk) begin
        if (save_now) begin
            // Every save includes the bus address
            nv_bus_addr <= next_bus_addr;
            if (link.ptr != REG_BUS_ADDR) begin
                // Commit or auto save copies every setting
                nv_divider <= next_divider;
                nv_trim <= next_trim;
                nv_offset <= next_offset;
            end
        end
    end

    // ==============================================================
    // Save timer; busy blocks all transfers
    // Loaded at the take edge, so busy starts with the answer
    // Silicon needs a long save; the bench shortens it by parameter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_count <= 32'h0000_0000;
        // A new save restarts the full wait
        end else if (save_now) begin
            nv_count <= 32'(NV_CYCLES);
        end else if (nv_count != 32'h0000_0000) begin
            nv_count <= nv_count - 32'h0000_0001;
        end
    end
    // Busy follows a register, so it never glitches
    assign nv_busy = nv_count != 32'h0000_0000;

    // ==============================================================
    // Answer one cycle after the request is taken
    // Refused transfers still answer, with the acknowledge clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.done <= 1'b0;
            link.ack <= 1'b0;
            link.rdata <= 16'h0000;
        end else begin
            // One answer pulse per taken request
            link.done <= take;
            // Acknowledge and data change only on a new take
            if (take) begin
                link.ack <= hit && !nv_busy;
                // Read data only moves on an accepted read
                if (hit && !nv_busy && link.rd) begin
                    link.rdata <= {rd_byte(link.ptr, divider, trim, bus_addr, offset),
                        rd_byte(link.ptr + 8'h01, divider, trim, bus_addr, offset)};
                end
            end
        end
    end

    // ==============================================================
    // Oscillator settings from working copies
    always_comb begin
        // Exponents above eight decode as eight
        divider_exponent = (divider[3:0] > EXP_MAX) ? EXP_MAX : divider[3:0];
        // Set selects the shallower dither
        dither_depth_select = divider[DITHER_BIT];
        offset_setting = offset;
        // Trim is left-justified; drop the empty low bits
        trim_value = trim[15:TRIM_SHIFT];
    end

    // Range minimum steps from the factory range; sign via wrap-around
    // Fractional output kilohertz are dropped by the shift
    always_comb begin
        master_khz = RANGE_BASE_KHZ
            + (32'(offset) - 32'(FACTORY_OS_RST)) * RANGE_STEP_KHZ
            + 32'(trim_value) * TRIM_STEP_KHZ;
        // Power-of-two divide is a plain right shift
        output_khz = master_khz >> divider_exponent;
    end
endmodule

// file: tb/nvc_link_sva.sv
`timescale 1ns/1ps
module nvc_link_sva
    import nvc_pkg::*;
#(
    parameter int NV_CYCLES = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic [6:0] dev_sel,
    input wire logic rd,
    input wire logic wide,
    input wire logic [7:0] ptr,
    input wire logic [15:0] wdata,
    input wire logic done,
    input wire logic ack,
    input wire logic [15:0] rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // Save window
    // Half the save time only, so the window never outlives the real save
    int save_left;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            save_left <= 0;
        end else if (done && ack && !rd && (ptr == REG_COMMIT || ptr == REG_BUS_ADDR)) begin
            save_left <= NV_CYCLES / 2;
        end else if (save_left != 0) begin
            save_left <= save_left - 1;
        end
    end
    // ==========================================
    // Link transfer checks
    a_answer_next: assert property (req && !done |=> done)
        else $error("no answer one cycle after take");
    a_done_single: assert property (done |=> !done)
        else $error("answer pulse longer than one cycle");
    a_done_cause: assert property ($rose(done) |-> $past(req))
        else $error("answer without request");
    a_req_drops: assert property (done |=> !req)
        else $error("request kept after answer");
    a_payload_held: assert property (req && !done
        |=> $stable({dev_sel, rd, wide, ptr, wdata}))
        else $error("request fields moved while pending");
    a_rdata_holds: assert property (!done |-> $stable(rdata) && $stable(ack))
        else $error("read data moved between answers");
    a_id_mismatch: assert property (req && !done && dev_sel[6:3] != DEV_ID_HI |=> !ack)
        else $error("foreign address acknowledged");
    a_save_refuses: assert property (done && save_left != 0 |-> !ack)
        else $error("transfer acknowledged during save");
endmodule

// file: tb/oscillator_nv_config_registers_test.sv
`timescale 1ns/1ps
module oscillator_nv_config_registers_test;
    import nvc_pkg::*;
    // ==========================================
    // Bench signals
    localparam int NV = 40; // Short save time for simulation
    localparam logic [31:0] MIN_KHZ = 32'h0001_01D0; // Lowest legal master
    localparam logic [31:0] MAX_KHZ = 32'h0002_0788; // Highest legal master
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] divider_exponent;
    logic dither_depth_select, nv_busy;
    logic [4:0] offset_setting;
    logic [9:0] trim_value;
    logic [31:0] master_khz, output_khz;
    int err_total = 0;
    int checked = 0;
    logic [6:0] dev = 7'h50; // Device address after reset
    logic ak; // Last link acknowledge
    logic [15:0] v; // Last link read data
    logic [1:0] rs; // Last bus response
    nvc_link_if link();
    nvc_controller i_nvc_controller(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(link));
    nvc_device #(.NV_CYCLES(NV)) i_nvc_device(.aclk, .aresetn, .link(link), .divider_exponent,
        .dither_depth_select, .offset_setting, .trim_value, .master_khz, .output_khz, .nv_busy);
    nvc_link_sva #(.NV_CYCLES(NV)) i_nvc_link_sva(.aclk(aclk), .aresetn(aresetn),
        .req(link.req), .dev_sel(link.dev_sel), .rd(link.rd), .wide(link.wide),
        .ptr(link.ptr), .wdata(link.wdata), .done(link.done), .ack(link.ack),
        .rdata(link.rdata));
    // ==========================================
    // Clock and watchdog
    initial begin
        forever #5 aclk = ~aclk;
    end
    // Whole run needs well under this
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        tally_and_finish();
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Bus write; both halves offered together, released as taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic bd;
        bd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bd) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                bd = 1'b1;
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        logic rdn;
        rdn = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rdn) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                rs = s_axi_rresp;
                rdn = 1'b1;
                s_axi_rready <= 1'b0;
            end
        end
    endtask
    // One link transfer through the controller, waiting for its end
    task automatic op(input logic r, input logic w, input logic [7:0] p, input logic [15:0] d);
        logic [31:0] st;
        axi_wr(CSR_WDATA, {16'h0000, d});
        axi_wr(CSR_CMD, {14'h0000, w, r, 1'b0, dev, p});
        st = 32'h0000_0001;
        while (st[0]) axi_rd(CSR_STATUS, st);
        ak = st[1];
        axi_rd(CSR_RDATA, st);
        v = st[15:0];
    endtask
    // Single reads come back in the high byte
    task automatic rdc(input string n, input logic w, input logic [7:0] p, input logic [15:0] e);
        op(1'b1, w, p, 16'h0000);
        chk(n, w ? {16'h0000, v} : {24'h00_0000, v[15:8]}, {16'h0000, e});
    endtask
    // ==========================================
    // Scenarios
    task automatic t_defaults();
        rdc("divider", 1'b0, REG_DIVIDER, 16'h00E0);
        rdc("trim word", 1'b1, REG_TRIM_HI, 16'h7D00);
        rdc("bus addr", 1'b0, REG_BUS_ADDR, 16'h00F0);
        chk("trim out", {22'h00_0000, trim_value}, 32'h0000_01F4);
        chk("master", master_khz, 32'h0001_7B88);
        chk("output", output_khz, 32'h0001_7B88);
        op(1'b0, 1'b0, REG_RANGE, 16'h0500);
        chk("range save", {31'h0, nv_busy}, 32'h0000_0000);
        rdc("range", 1'b0, REG_RANGE, 16'h0012);
    endtask
    task automatic t_autosave();
        op(1'b0, 1'b0, REG_DIVIDER, 16'h0300);
        chk("auto save", {31'h0, nv_busy}, 32'h0000_0001);
        chk("dither", {31'h0, dither_depth_select}, 32'h0000_0000);
        chk("divided", output_khz, 32'h0000_2F71);
        op(1'b1, 1'b0, REG_DIVIDER, 16'h0000);
        chk("busy ack", {31'h0, ak}, 32'h0000_0000);
        repeat (NV) @(posedge aclk);
        rdc("divider", 1'b0, REG_DIVIDER, 16'h0003);
    endtask
    task automatic t_defer();
        logic in_band;
        op(1'b0, 1'b0, REG_BUS_ADDR, 16'h0B00);
        chk("addr save", {31'h0, nv_busy}, 32'h0000_0001);
        dev = 7'h53;
        op(1'b1, 1'b0, REG_DIVIDER, 16'h0000);
        chk("save nack", {31'h0, ak}, 32'h0000_0000);
        repeat (NV) @(posedge aclk);
        dev = 7'h50;
        op(1'b1, 1'b0, REG_DIVIDER, 16'h0000);
        chk("old addr ack", {31'h0, ak}, 32'h0000_0000);
        dev = 7'h53;
        op(1'b0, 1'b0, REG_DIVIDER, 16'h0F00);
        chk("new addr ack", {31'h0, ak}, 32'h0000_0001);
        chk("deferred", {31'h0, nv_busy}, 32'h0000_0000);
        chk("clamp", {28'h000_0000, divider_exponent}, 32'h0000_0008);
        op(1'b1, 1'b0, REG_RANGE, 16'h0000);
        op(1'b0, 1'b0, REG_OFFSET, {3'b000, v[12:8] - 5'h02, 8'h00});
        chk("offset", {27'h000_0000, offset_setting}, 32'h0000_0010);
        op(1'b0, 1'b1, REG_TRIM_HI, 16'hA3C0);
        op(1'b0, 1'b0, REG_DIVIDER, 16'h1300);
        chk("dither", {31'h0, dither_depth_select}, 32'h0000_0001);
        chk("trim out", {22'h00_0000, trim_value}, 32'h0000_028F);
        chk("master", master_khz, 32'h0001_5996);
        in_band = master_khz >= MIN_KHZ && master_khz <= MAX_KHZ;
        chk("band", {31'h0, in_band}, 32'h0000_0001);
        chk("output", output_khz, 32'h0000_2B32);
        rdc("trim word", 1'b1, REG_TRIM_HI, 16'hA3C0);
        op(1'b0, 1'b0, REG_COMMIT, 16'h0000);
        chk("commit", {31'h0, nv_busy}, 32'h0000_0001);
        repeat (NV) @(posedge aclk);
        op(1'b0, 1'b0, REG_DIVIDER, 16'h0500);
        do_reset();
        @(posedge aclk);
        chk("kept exp", {28'h000_0000, divider_exponent}, 32'h0000_0003);
        chk("kept master", master_khz, 32'h0001_5996);
        rdc("bus addr", 1'b0, REG_BUS_ADDR, 16'h00FB);
    endtask
    task automatic t_refusals();
        logic [31:0] d;
        dev = 7'h13;
        op(1'b1, 1'b0, REG_RANGE, 16'h0000);
        chk("foreign ack", {31'h0, ak}, 32'h0000_0000);
        dev = 7'h53;
        axi_wr(CSR_STATUS, 32'h0000_0000);
        chk("unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
        axi_rd(4'h2, d);
        chk("unmapped rd", {30'h0, rs}, {30'h0, RESP_SLVERR});
        chk("unmapped data", d, 32'h0000_0000);
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        do_reset();
        t_defaults();
        t_autosave();
        t_defer();
        t_refusals();
        tally_and_finish();
    end
endmodule
